// [cpu_model.sv]
// processor core model driving the register bus and interrupt acknowledge
`timescale 1ns/1ns
`default_nettype none
module cpu_model
(
   input wire logic sys_clk,
   input wire logic [15:0] cpu_rdata,
   output logic [15:0] cpu_addr,
   output logic cpu_wr,
   output logic cpu_rd,
   output logic [15:0] cpu_wdata,
   output logic irq_ack
);
   // ------------------------------
   // bus cycles
   // ------------------------------
   // strobes low from time zero, so nothing is taken during reset
   initial
   begin
      {cpu_addr, cpu_wr, cpu_rd, cpu_wdata, irq_ack} = '0;
   end
   // released address and data turn to their inverse, never a stale copy
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge sys_clk);
      cpu_wr <= 1'b0;
      cpu_addr <= ~a;
      cpu_wdata <= ~d;
   endtask
   // read data lands on the taking edge and is picked up 1 ns later
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      @(posedge sys_clk);
      cpu_rd <= 1'b0;
      cpu_addr <= ~a;
      #1 d = cpu_rdata;
   endtask
   task automatic ack();
      @(posedge sys_clk);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
   endtask
endmodule // cpu_model
`default_nettype wire

// [hw_reg_space.sv]
// processor-side hardware register space with dac, pins and interrupts
//
// Overview of operation
// - control port at c000..c00f, record at c010
// - record bit 4 flags last access write
// - record low bits hold address; read-only
// - stream word returns last two bytes, earlier high
// - every fourth cycle add 20-bit increment
// - overflow loads samples and raises dac event
// - rate registers read-write, high holds pll bits
// - direction bit one makes pin output
// - output register kept while pin is input
// - input register returns sampled pin levels
// - pin port never raises an interrupt
// - enable bits map the eight sources
// - enable change takes effect within six cycles
// - push write increments nesting counter
// - pop write decrements unless already zero
// - zero count delivers enabled interrupts again
// - taking interrupt increments nesting counter
// - nesting counter readable, writable, nonzero blocks
// - host reaches registers via memory address, data
`timescale 1ns/1ns
`default_nettype none
module hw_reg_space
   import hw_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   // processor data bus
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [15:0] cpu_wdata,
   output logic [15:0] cpu_rdata,
   // host indirect access through memory address and data registers
   input wire logic host_mem_wr,
   input wire logic host_mem_rd,
   input wire logic [15:0] host_mem_addr,
   input wire logic [15:0] host_mem_data,
   output logic [15:0] host_rdata,
   // external control-port access report
   input wire logic ctrl_access,
   input wire logic ctrl_access_write,
   input wire logic [3:0] ctrl_access_addr,
   input wire logic [15:0] ctrl_port_rdata,
   // serial stream bytes
   input wire logic stream_byte_valid,
   input wire logic [7:0] stream_input,
   input wire logic stream_word_event,
   output logic data_request_pin,
   // other interrupt sources: timers, uart, modulator
   input wire logic [7:0] ext_irq_events,
   // dac outputs
   output logic [15:0] dac_left,
   output logic [15:0] dac_right,
   output logic dac_sample_tick,
   output logic [15:0] pll_ctrl,
   // general purpose pins
   input wire logic [3:0] gpio_in,
   output logic [3:0] gpio_out,
   output logic [3:0] gpio_oe,
   // processor interrupt
   output logic irq_req,
   output logic [2:0] irq_vector,
   input wire logic irq_ack
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [5:0] last_ctrl_access;
      logic [15:0] stream_last_word;
      logic request_pin_ctrl;
      logic [15:0] rate_increment_low;
      logic [15:0] rate_increment_high_pll;
      logic [15:0] left_sample;
      logic [15:0] right_sample;
      logic [3:0] pin_direction;
      logic [3:0] pin_input_levels;
      logic [3:0] pin_output_levels;
      logic [7:0] irq_enable_mask;
      logic [15:0] cpu_rdata;
      logic [15:0] host_rdata;
   } state_t;
   state_t s_q, s_d;

   irq_req_if irq_bus ();
   logic wr;
   logic rd;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic sample_tick;

   // ------------------------------------------------------------
   // decoding
   // ------------------------------------------------------------

   // read mux shared by processor and host paths
   function automatic logic [15:0] read_reg(input state_t s, input logic [15:0] a,
                                            input logic [4:0] nest,
                                            input logic [15:0] cport);
      read_reg = 16'h0000;
      if (a >= ctrl_port_base && a <= ctrl_port_last)
         read_reg = cport;
      else
         case (a)
            addr_last_ctrl_access: read_reg = {10'h000, s.last_ctrl_access};
            addr_stream_last_word: read_reg = s.stream_last_word;
            addr_rate_increment_low: read_reg = s.rate_increment_low;
            addr_rate_increment_high_pll: read_reg = s.rate_increment_high_pll;
            addr_left_sample: read_reg = s.left_sample;
            addr_right_sample: read_reg = s.right_sample;
            addr_pin_direction: read_reg = {12'h000, s.pin_direction};
            addr_pin_input_levels: read_reg = {12'h000, s.pin_input_levels};
            addr_pin_output_levels: read_reg = {12'h000, s.pin_output_levels};
            addr_irq_enable_mask: read_reg = {8'h00, s.irq_enable_mask};
            addr_irq_nesting_count: read_reg = {11'h000, nest};
            default: read_reg = 16'h0000;
         endcase
   endfunction

   // host write takes the bus when both write at once; processor waits never
   assign wr = cpu_wr | host_mem_wr;
   assign addr = host_mem_wr ? host_mem_addr : cpu_addr;
   assign wdata = host_mem_wr ? host_mem_data : cpu_wdata;
   assign rd = cpu_rd;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      // record of control-port traffic, never written by software
      if (ctrl_access)
      begin
         s_d.last_ctrl_access[last_access_write_flag_bit] = ctrl_access_write;
         s_d.last_ctrl_access[3:0] = ctrl_access_addr;
         s_d.last_ctrl_access[5] = 1'b0;
      end
      // shift bytes in so the older byte lands high
      if (stream_byte_valid)
         s_d.stream_last_word = {s_q.stream_last_word[7:0], stream_input};
      s_d.pin_input_levels = gpio_in;
      if (wr)
         case (addr)
            addr_request_pin_ctrl: s_d.request_pin_ctrl = wdata[0];
            addr_rate_increment_low: s_d.rate_increment_low = wdata;
            addr_rate_increment_high_pll: s_d.rate_increment_high_pll = wdata;
            addr_left_sample: s_d.left_sample = wdata;
            addr_right_sample: s_d.right_sample = wdata;
            addr_pin_direction: s_d.pin_direction = wdata[3:0];
            addr_pin_output_levels: s_d.pin_output_levels = wdata[3:0];
            addr_irq_enable_mask: s_d.irq_enable_mask = wdata[7:0];
            default: s_d.request_pin_ctrl = s_q.request_pin_ctrl;
         endcase
      s_d.cpu_rdata = rd ? read_reg(s_q, cpu_addr, irq_bus.nest_count, ctrl_port_rdata)
                         : s_q.cpu_rdata;
      s_d.host_rdata = host_mem_rd
         ? read_reg(s_q, host_mem_addr, irq_bus.nest_count, ctrl_port_rdata)
         : s_q.host_rdata;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ------------------------------------------------------------
   // dac rate generator
   // ------------------------------------------------------------
   rate_accum u_rate
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .increment({s_q.rate_increment_high_pll[rate_high_inc_bits-1:0],
                  s_q.rate_increment_low}),
      .left_in(s_q.left_sample),
      .right_in(s_q.right_sample),
      .left_out(dac_left),
      .right_out(dac_right),
      .sample_tick(sample_tick)
   );

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   // pins feed no source: bit 1 from port traffic, 2 from the stream word event, 0 from dac
   always_comb
   begin
      irq_bus.events = ext_irq_events & 8'hf8;
      irq_bus.events[irq_dac_bit] = sample_tick;
      irq_bus.events[irq_ctrl_bit] = ctrl_access;
      irq_bus.events[irq_stream_bit] = stream_word_event;
   end
   assign irq_bus.enable_mask = s_q.irq_enable_mask;
   assign irq_bus.push = wr && addr == addr_irq_block_push;
   assign irq_bus.pop = wr && addr == addr_irq_block_pop;
   assign irq_bus.count_wr = wr && addr == addr_irq_nesting_count;
   assign irq_bus.count_wdata = wdata[4:0];
   assign irq_bus.irq_ack = irq_ack;

   irq_ctrl u_irq
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .bus(irq_bus)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign cpu_rdata = s_q.cpu_rdata;
   assign host_rdata = s_q.host_rdata;
   assign data_request_pin = s_q.request_pin_ctrl;
   assign dac_sample_tick = sample_tick;
   assign pll_ctrl = {4'h0, s_q.rate_increment_high_pll[15:rate_high_inc_bits]};
   assign gpio_out = s_q.pin_output_levels;
   assign gpio_oe = s_q.pin_direction;
   assign irq_req = irq_bus.irq_req;
   assign irq_vector = irq_bus.irq_vector;
endmodule // hw_reg_space
`default_nettype wire

// [hw_reg_space_monitor.sv]
// port checker for the hardware register space
`timescale 1ns/1ns
`default_nettype none
module hw_reg_space_monitor
   import hw_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [15:0] cpu_wdata,
   input wire logic [15:0] cpu_rdata,
   input wire logic host_mem_wr,
   input wire logic [15:0] ctrl_port_rdata,
   input wire logic [15:0] dac_left,
   input wire logic [15:0] dac_right,
   input wire logic dac_sample_tick,
   input wire logic [3:0] gpio_oe,
   input wire logic irq_req,
   input wire logic irq_ack
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // host write wins a clash, so only lone cpu writes are judged
   wire logic cw = cpu_wr && !host_mem_wr;

   a_ctrl_port_read: assert property (
      cpu_rd && cpu_addr >= ctrl_port_base && cpu_addr <= ctrl_port_last
      |=> cpu_rdata == $past(ctrl_port_rdata)) else $error("control port read wrong");
   a_record_upper_zero: assert property (
      cpu_rd && cpu_addr == addr_last_ctrl_access |=> cpu_rdata[15:5] == 11'h000)
      else $error("record upper bits set");
   a_pin_dir_write: assert property (
      cw && cpu_addr == addr_pin_direction |=> gpio_oe == $past(cpu_wdata[3:0]))
      else $error("pin enables not written");
   a_pin_dir_hold: assert property (
      !cpu_wr && !host_mem_wr |=> $stable(gpio_oe)) else $error("pin enables moved");
   a_tick_spacing: assert property (
      dac_sample_tick |=> !dac_sample_tick [*3]) else $error("ticks too close");
   a_samples_on_tick: assert property (
      $changed(dac_left) || $changed(dac_right) |-> dac_sample_tick)
      else $error("samples moved without tick");
   a_ack_drops_req: assert property (
      irq_ack && irq_req |=> !irq_req) else $error("request kept after ack");
   a_push_blocks: assert property (
      cw && cpu_addr == addr_irq_block_push |-> ##[1:6] !irq_req)
      else $error("push did not block");
   a_mask_off_blocks: assert property (
      cw && cpu_addr == addr_irq_enable_mask && cpu_wdata[7:0] == 8'h00 |-> ##[1:6] !irq_req)
      else $error("mask clear did not block");
endmodule // hw_reg_space_monitor

bind hw_reg_space hw_reg_space_monitor mon (.sys_clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd,
   .cpu_wdata, .cpu_rdata, .host_mem_wr, .ctrl_port_rdata, .dac_left, .dac_right,
   .dac_sample_tick, .gpio_oe, .irq_req, .irq_ack);
`default_nettype wire

// [hw_reg_space_tb.sv]
// self-checking bench for the hardware register space
`timescale 1ns/1ns
`default_nettype none
module hw_reg_space_tb
   import hw_regs_pkg::*;
;
   logic sys_clk, rst, cpu_wr, cpu_rd, host_mem_wr, host_mem_rd, ctrl_access, ctrl_access_write;
   logic stream_byte_valid, stream_word_event, data_request_pin, dac_sample_tick, irq_req, irq_ack;
   logic [15:0] cpu_addr, cpu_wdata, cpu_rdata, host_mem_addr, host_mem_data, host_rdata, rv;
   logic [15:0] ctrl_port_rdata, dac_left, dac_right, pll_ctrl;
   logic [7:0] stream_input, ext_irq_events;
   logic [3:0] ctrl_access_addr, gpio_in, gpio_out, gpio_oe;
   logic [2:0] irq_vector;
   int num_errors, checks_done, n;

   hw_reg_space dut (.sys_clk, .rst, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
      .host_mem_wr, .host_mem_rd, .host_mem_addr, .host_mem_data, .host_rdata, .ctrl_access,
      .ctrl_access_write, .ctrl_access_addr, .ctrl_port_rdata, .stream_byte_valid,
      .stream_input, .stream_word_event, .data_request_pin, .ext_irq_events, .dac_left,
      .dac_right, .dac_sample_tick, .pll_ctrl, .gpio_in, .gpio_out, .gpio_oe, .irq_req,
      .irq_vector, .irq_ack);
   cpu_model cpu (.sys_clk, .cpu_rdata, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .irq_ack);

   // ------------------------------
   // helpers
   // ------------------------------
   // 100 ns period
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic close_out();
      $display("errors %0d of %0d checks", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [15:0] a, input logic [15:0] e);
      cpu.rd(a, rv);
      chk(rv, e);
   endtask
   // bounded wait on the tick (pick 1) or the request; a hang ends the run
   task automatic wait_for(input logic pick, input int lim, output int k);
      k = 0;
      do
      begin
         @(posedge sys_clk);
         #1 k++;
      end
      while ((pick ? dac_sample_tick : irq_req) !== 1'b1 && k < lim);
      if (k >= lim)
      begin
         num_errors++;
         close_out();
      end
   endtask
   task automatic ctrl_op(input logic w, input logic [3:0] a);
      @(posedge sys_clk);
      ctrl_access <= 1'b1;
      ctrl_access_write <= w;
      ctrl_access_addr <= a;
      @(posedge sys_clk);
      ctrl_access <= 1'b0;
   endtask
   task automatic host_op(input logic w, input logic [15:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {host_mem_wr, host_mem_rd, host_mem_addr, host_mem_data} <= {w, !w, a, d};
      @(posedge sys_clk);
      {host_mem_wr, host_mem_rd, host_mem_data} <= {2'b00, ~d};
      #1;
   endtask
   task automatic byte_in(input logic [7:0] b);
      @(posedge sys_clk);
      stream_byte_valid <= 1'b1;
      stream_input <= b;
      @(posedge sys_clk);
      stream_byte_valid <= 1'b0;
      stream_input <= ~b;
   endtask
   // bit 0 is left pending by the dac ticks
   task automatic raise(input int i);
      if (i == 1)
         ctrl_op(1'b0, 4'h0);
      else
      begin
         @(posedge sys_clk);
         stream_word_event <= (i == 2);
         ext_irq_events <= (i > 2) ? 8'h01 << i : 8'h00;
         @(posedge sys_clk);
         {stream_word_event, ext_irq_events} <= '0;
      end
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_reset();
      logic [15:0] ad [12] = '{16'hc010, 16'hc011, 16'hc013, 16'hc014, 16'hc015, 16'hc016,
         16'hc017, 16'hc018, 16'hc019, 16'hc01a, 16'hc01d, 16'hc0f0};
      foreach (ad[i])
         rc(ad[i], 16'h0000);
   endtask
   task automatic t_rw();
      logic [15:0] ad [8] = '{16'hc013, 16'hc014, 16'hc015, 16'hc016, 16'hc017, 16'hc019,
         16'hc01a, 16'hc01d};
      logic [15:0] mk [8] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h000f, 16'h000f,
         16'h00ff, 16'h001f};
      foreach (ad[i])
      begin
         cpu.wr(ad[i], 16'h5aa5);
         rc(ad[i], 16'h5aa5 & mk[i]);
         cpu.wr(ad[i], 16'h0000);
      end
   endtask
   task automatic t_record();
      ctrl_port_rdata <= 16'hbeef;
      rc(16'hc003, 16'hbeef);
      ctrl_op(1'b1, 4'h9);
      rc(16'hc010, 16'h0019);
      ctrl_op(1'b0, 4'h3);
      cpu.wr(16'hc010, 16'hffff);
      rc(16'hc010, 16'h0003);
   endtask
   task automatic t_stream();
      byte_in(8'h12);
      byte_in(8'h34);
      rc(16'hc011, 16'h1234);
      byte_in(8'h56);
      rc(16'hc011, 16'h3456);
      cpu.wr(16'hc012, 16'h0001);
      #1 chk({15'h0, data_request_pin}, 16'h0001);
   endtask
   task automatic t_gpio();
      cpu.wr(16'hc019, 16'h000a);
      cpu.wr(16'hc017, 16'h0000);
      #1 chk({12'h0, gpio_oe}, 16'h0000);
      cpu.wr(16'hc017, 16'h000f);
      #1 chk({8'h0, gpio_oe, gpio_out}, 16'h00fa);
      gpio_in <= 4'h6;
      repeat (4) @(posedge sys_clk);
      rc(16'hc018, 16'h0006);
      host_op(1'b1, 16'hc019, 16'h0005);
      rc(16'hc019, 16'h0005);
      host_op(1'b0, 16'hc019, 16'h0000);
      chk(host_rdata, 16'h0005);
      cpu.wr(16'hc017, 16'h0000);
   endtask
   // increment 0x80000 overflows 26 bits every 128 adds, whatever the residue
   task automatic t_dac();
      cpu.wr(16'hc015, 16'h1111);
      cpu.wr(16'hc016, 16'h2222);
      cpu.wr(16'hc014, 16'h1238);
      #1 chk(pll_ctrl, 16'h0123);
      wait_for(1'b1, 600, n);
      chk(dac_left, 16'h1111);
      chk(dac_right, 16'h2222);
      wait_for(1'b1, 600, n);
      chk(n[15:0], 16'h0200);
      cpu.wr(16'hc015, 16'h3333);
      wait_for(1'b1, 600, n);
      chk(dac_left, 16'h3333);
      cpu.wr(16'hc014, 16'h0000);
   endtask
   task automatic t_irq();
      for (int i = 0; i < 8; i++)
      begin
         cpu.wr(16'hc01b, 16'h0000);
         cpu.wr(16'hc01a, 16'h0001 << i);
         raise(i);
         repeat (8) @(posedge sys_clk);
         #1 chk({15'h0, irq_req}, 16'h0000);
         cpu.wr(16'hc01c, 16'h0000);
         wait_for(1'b0, 12, n);
         chk({13'h0, irq_vector}, 16'(i));
         cpu.ack();
         rc(16'hc01d, 16'h0001);
         cpu.wr(16'hc01c, 16'h0000);
      end
      cpu.wr(16'hc01c, 16'h0000);
      rc(16'hc01d, 16'h0000);
      // all sources enabled and unblocked, yet pin moves must stay silent
      cpu.wr(16'hc01a, 16'h00ff);
      gpio_in <= 4'h9;
      repeat (8) @(posedge sys_clk);
      #1 chk({15'h0, irq_req}, 16'h0000);
      cpu.wr(16'hc01b, 16'h0000);
      cpu.wr(16'hc01b, 16'h0000);
      rc(16'hc01d, 16'h0002);
      cpu.wr(16'hc01d, 16'h0000);
      rc(16'hc01d, 16'h0000);
      cpu.wr(16'hc01a, 16'h0000);
   endtask

   // main sequence
   initial
   begin
      rst = 1'b1;
      {host_mem_wr, host_mem_rd, ctrl_access, ctrl_access_write, stream_byte_valid} = '0;
      {stream_word_event, host_mem_addr, host_mem_data, ctrl_port_rdata} = '0;
      {ctrl_access_addr, gpio_in, stream_input, ext_irq_events} = '0;
      num_errors = 0;
      checks_done = 0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_rw();
      t_record();
      t_stream();
      t_gpio();
      t_dac();
      t_irq();
      close_out();
   end
endmodule // hw_reg_space_tb
`default_nettype wire

// [hw_regs_pkg.sv]
// constants shared by the hardware register space modules
`default_nettype none
package hw_regs_pkg;
   localparam logic [15:0] addr_last_ctrl_access = 16'hc010;
   localparam logic [15:0] addr_stream_last_word = 16'hc011;
   localparam logic [15:0] addr_request_pin_ctrl = 16'hc012;
   localparam logic [15:0] addr_rate_increment_low = 16'hc013;
   localparam logic [15:0] addr_rate_increment_high_pll = 16'hc014;
   localparam logic [15:0] addr_left_sample = 16'hc015;
   localparam logic [15:0] addr_right_sample = 16'hc016;
   localparam logic [15:0] addr_pin_direction = 16'hc017;
   localparam logic [15:0] addr_pin_input_levels = 16'hc018;
   localparam logic [15:0] addr_pin_output_levels = 16'hc019;
   localparam logic [15:0] addr_irq_enable_mask = 16'hc01a;
   localparam logic [15:0] addr_irq_block_push = 16'hc01b;
   localparam logic [15:0] addr_irq_block_pop = 16'hc01c;
   localparam logic [15:0] addr_irq_nesting_count = 16'hc01d;
   localparam logic [15:0] ctrl_port_base = 16'hc000;
   localparam logic [15:0] ctrl_port_last = 16'hc00f;
   // field positions, widths, counts and delays
   localparam int last_access_write_flag_bit = 4;
   localparam int rate_high_inc_bits = 4;
   localparam int rate_acc_width = 26;
   localparam int rate_step_period = 4;
   localparam int irq_sources = 8;
   localparam int irq_dac_bit = 0;
   localparam int irq_ctrl_bit = 1;
   localparam int irq_stream_bit = 2;
   localparam int nest_width = 5;
   localparam int enable_delay = 6;
   // reset values
   localparam logic [15:0] reg_reset_value = 16'h0000;
endpackage
`default_nettype wire

// [irq_ctrl.sv]
// interrupt pending, enable delay and nesting counter
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl
   import hw_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   irq_req_if.ctrl bus
);
   typedef struct packed
   {
      logic [7:0] pending;
      logic [7:0] en_dly;
      logic [4:0] count;
      logic req;
      logic [2:0] vec;
   } state_t;
   state_t s_q, s_d;
   logic [7:0] ready;

   // lowest set bit picks the vector
   function automatic logic [2:0] pick(input logic [7:0] v);
      pick = 3'h0;
      for (int i = 7; i >= 0; i--)
         if (v[i])
            pick = 3'(i);
   endfunction

   // enable copy lags one cycle, well inside the six allowed
   always_comb
   begin
      s_d = s_q;
      s_d.en_dly = bus.enable_mask;
      ready = s_q.pending & s_q.en_dly;
      s_d.pending = s_q.pending | bus.events;
      if (bus.count_wr)
         s_d.count = bus.count_wdata;
      else if (bus.push || bus.irq_ack)
         s_d.count = s_q.count + 5'h1;
      else if (bus.pop && s_q.count != 5'h0)
         s_d.count = s_q.count - 5'h1;
      s_d.req = (s_q.count == 5'h0) && (ready != 8'h00) && !bus.irq_ack;
      s_d.vec = pick(ready);
      if (bus.irq_ack)
         s_d.pending[s_q.vec] = bus.events[s_q.vec]; // new event wins over clear
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign bus.nest_count = s_q.count;
   assign bus.irq_req = s_q.req;
   assign bus.irq_vector = s_q.vec;
endmodule // irq_ctrl
`default_nettype wire

// [irq_req_if.sv]
// interface carrying interrupt events and delivery between modules
`timescale 1ns/1ns
`default_nettype none
interface irq_req_if;
   logic [7:0] events;
   logic [7:0] enable_mask;
   logic [4:0] nest_count;
   logic push;
   logic pop;
   logic count_wr;
   logic [4:0] count_wdata;
   logic irq_req;
   logic [2:0] irq_vector;
   logic irq_ack;
   modport ctrl
   (
      input events, enable_mask, push, pop, count_wr, count_wdata, irq_ack,
      output nest_count, irq_req, irq_vector
   );
   modport regs
   (
      output events, enable_mask, push, pop, count_wr, count_wdata, irq_ack,
      input nest_count, irq_req, irq_vector
   );
endinterface
`default_nettype wire

// [rate_accum.sv]
// dac sample-rate phase accumulator with sample capture
`timescale 1ns/1ns
`default_nettype none
module rate_accum
   import hw_regs_pkg::*;
#(
   parameter int acc_width = rate_acc_width
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [19:0] increment,
   input wire logic [15:0] left_in,
   input wire logic [15:0] right_in,
   output logic [15:0] left_out,
   output logic [15:0] right_out,
   output logic sample_tick
);
   typedef struct packed
   {
      logic [1:0] phase;
      logic [acc_width-1:0] acc;
      logic [15:0] left;
      logic [15:0] right;
      logic tick;
   } state_t;
   state_t s_q, s_d;
   logic [acc_width:0] sum;

   // add once every fourth cycle; carry out loads the converter
   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.phase = s_q.phase + 2'h1;
      sum = {1'b0, s_q.acc} + (acc_width + 1)'(increment);
      if (s_q.phase == 2'(rate_step_period - 1))
      begin
         s_d.acc = sum[acc_width-1:0];
         if (sum[acc_width])
         begin
            s_d.left = left_in;
            s_d.right = right_in;
            s_d.tick = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign left_out = s_q.left;
   assign right_out = s_q.right;
   assign sample_tick = s_q.tick;
endmodule // rate_accum
`default_nettype wire
